/* src/pwie_top.sv */
// port wake and interrupt events: six port register pages behind an apb slave,
// drives the power event pin and a block interrupt line.
// assumes event inputs are level or pulse signals from other clock domains,
// the filter-table event is a pulse in this clock domain.
// Summary of operation
// - matching wake packet sets wake flag bit 2; software clears it by writing one.
// - link-up sets flag bit 1, held until software clears by write.
// - cable energy sets flag bit 0, held until software clears by write.
// - link-up and energy bits only work on phy ports; mac-only port stays clear.
// - enable bit 2 lets wake packet detection assert the power event pin.
// - enable bit 1 lets link-up detection assert the power event pin.
// - enable bit 0 lets energy detection assert the power event pin.
// - status bit 1 shows pending phy interrupts; zero on the mac-only port.
// - status bit 0 set by a filter-table counter event on any port.
// - filter status not write-clearable; toggling its mask bit clears it.
// - each status bit interrupts only when its mask bit enables it.
// - mask bits inverted: zero enables, one disables; both reset to zero.
// - filter mask bit exists on every port, including the mac-only port.
`timescale 1ns/1ps
`include "pwie_map.svh"

module pwie_top
	import pwie_pkg::*;
#(
	parameter int PORTS = PWIE_PORTS,
	parameter logic [PWIE_PORTS-1:0] PHY_PORTS = 6'h1F
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [15:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic pready_out,
	output logic [31:0] prdata_out,
	output logic pslverr_out,
	// per-port events from the mac and phy logic
	input wire logic [PWIE_PORTS-1:0] wake_pkt_in,
	input wire logic [PWIE_PORTS-1:0] link_up_in,
	input wire logic [PWIE_PORTS-1:0] energy_in,
	input wire logic [PWIE_PORTS-1:0] phy_int_in,
	input wire logic [PWIE_PORTS-1:0] filter_int_in,
	// pins and interrupt
	output logic power_event_out,
	output logic irq_out
);

	// block state apart from the synchronisers lives in one packed struct, registered by one process
	pwie_state_t s_r;
	pwie_state_t s_nxt;

	// event inputs grouped by kind; bit p of each vector belongs to port p+1
	logic [PWIE_PORTS-1:0] raw [4];
	logic [PWIE_PORTS-1:0] rise [4];
	logic [PWIE_PORTS-1:0] lvl [4];

	// the filter-table event is made on this clock and needs no synchroniser
	assign raw[0] = wake_pkt_in;
	assign raw[1] = link_up_in;
	assign raw[2] = energy_in;
	assign raw[3] = phy_int_in;

	// three-stage synchronisers for events from other domains.
	// stage one is read only by stage two, so a metastable value never fans out.
	// a change counts once stages two and three agree; the agreed value is kept
	// so that a level held for many cycles yields exactly one rising event.
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_sync
			logic [PWIE_PORTS-1:0] sy1_r;
			logic [PWIE_PORTS-1:0] sy2_r;
			logic [PWIE_PORTS-1:0] sy3_r;
			logic [PWIE_PORTS-1:0] agreed_r;
			logic [PWIE_PORTS-1:0] same;

			// per-bit agreement of the two late stages
			assign same = ~(sy2_r ^ sy3_r);

			// shift chain plus the last agreed value; idle pins are low after reset
			always_ff @(posedge clk_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					sy1_r <= '0;
					sy2_r <= '0;
					sy3_r <= '0;
					agreed_r <= '0;
				end else begin
					sy1_r <= raw[g];
					sy2_r <= sy1_r;
					sy3_r <= sy2_r;
					agreed_r <= (same & sy3_r) | (~same & agreed_r);
				end
			end

			// a new high value once both late stages agree on it
			assign rise[g] = same & sy3_r & ~agreed_r;
			// level counted only while both late stages agree that it is high
			assign lvl[g] = sy2_r & sy3_r;
		end
	endgenerate

	// address decode: page is the port number, the word index sits in bits 11:2,
	// so the byte address of a register is its index times four.
	// pages above PORTS and misaligned addresses hit nothing and answer with an error.
	logic [3:0] page;
	logic [11:0] idx;
	logic [2:0] pn;
	logic aligned;
	logic page_port;
	logic page_glob;
	logic hit_wflags;
	logic hit_wen;
	logic hit_iflags;
	logic hit_imask;
	logic hit_gstat;
	logic hit_gmask;
	logic hit_port;
	logic hit_glob;
	logic access;
	logic wr_en;
	logic rd_en;

	// page and index fields
	assign page = paddr_in[`PWIE_PAGE_MSB:`PWIE_PAGE_LSB];
	assign idx = {2'h0, paddr_in[11:2]};
	assign pn = page[2:0] - 3'h1;
	assign aligned = (paddr_in[1:0] == 2'h0);
	assign page_port = (page >= 4'h1) && (page <= 4'(PORTS)) && aligned;
	assign page_glob = (page == 4'h0) && aligned;

	// one hit per register word; every port page holds the same four words
	assign hit_wflags = page_port && (idx == `PWIE_IDX_WAKE_FLAGS);
	assign hit_wen = page_port && (idx == `PWIE_IDX_WAKE_ENABLES);
	assign hit_iflags = page_port && (idx == `PWIE_IDX_INT_FLAGS);
	assign hit_imask = page_port && (idx == `PWIE_IDX_INT_MASK);
	assign hit_gstat = page_glob && (idx == `PWIE_IDX_IRQ_STATUS);
	assign hit_gmask = page_glob && (idx == `PWIE_IDX_IRQ_MASK);
	assign hit_port = hit_wflags || hit_wen || hit_iflags || hit_imask;
	assign hit_glob = hit_gstat || hit_gmask;

	// first access cycle: the bus machine is still idle, read data is captured here
	assign access = psel_in && penable_in && (s_r.bus == PWIE_IDLE);
	// writes land only at the edge where ready is high, so a slow master never writes twice;
	// only byte lane 0 carries register bits, a write without it is ignored
	assign wr_en = psel_in && penable_in && pwrite_in && (s_r.bus == PWIE_ACK) && pstrb_in[0];
	assign rd_en = access && !pwrite_in;

	// per-port terms, one copy of the same logic for each port
	logic [PWIE_PORTS-1:0] port_sel;
	logic [PWIE_PORTS-1:0] phy_live;
	logic [PWIE_PORTS-1:0] wake_hit;
	logic [PWIE_PORTS-1:0] pend;
	logic [2:0] wake_set [PWIE_PORTS];
	logic [7:0] port_rd [PWIE_PORTS];

	generate
		for (g = 0; g < PWIE_PORTS; g++) begin : g_port
			// mac-only ports have no link or energy detection and no phy summary
			localparam logic IS_PHY = PHY_PORTS[g];
			logic [2:0] set_w;
			logic [7:0] word;

			// this port's page is addressed
			assign port_sel[g] = (pn == 3'(g));

			// new events are synchronised rising edges
			always_comb begin
				set_w = 3'h0;
				set_w[`PWIE_BIT_WAKE_PKT] = rise[0][g];
				set_w[`PWIE_BIT_LINK_UP] = rise[1][g] & IS_PHY;
				set_w[`PWIE_BIT_ENERGY] = rise[2][g] & IS_PHY;
			end
			assign wake_set[g] = set_w;

			// phy summary is a live level, zero on a mac-only port
			assign phy_live[g] = lvl[3][g] & IS_PHY;

			// latched flags gated by their enables request the power event pin
			assign wake_hit[g] = |(s_r.port[g].wake_flags & s_r.port[g].wake_en);

			// inverted mask: a zero lets the status through
			assign pend[g] = (s_r.port[g].filter_flag & ~s_r.port[g].mask[`PWIE_BIT_FILTER_INT]) |
				(phy_live[g] & ~s_r.port[g].mask[`PWIE_BIT_PHY_INT]);

			// read word of this port; reserved upper bits stay zero
			always_comb begin
				word = 8'h00;
				if (hit_wflags) begin
					word[2:0] = s_r.port[g].wake_flags;
				end else if (hit_wen) begin
					word[2:0] = s_r.port[g].wake_en;
				end else if (hit_iflags) begin
					word[`PWIE_BIT_PHY_INT] = phy_live[g];
					word[`PWIE_BIT_FILTER_INT] = s_r.port[g].filter_flag;
				end else if (hit_imask) begin
					word[1:0] = s_r.port[g].mask;
				end
			end
			assign port_rd[g] = word;
		end
	endgenerate

	// next state: bus sequencing, register writes, event capture, pins
	always_comb begin
		logic [7:0] wd;
		logic [7:0] rd;
		logic pev;
		wd = pwdata_in[7:0];
		rd = 8'h00;
		pev = 1'b0;
		s_nxt = s_r;
		s_nxt.pslverr = 1'b0;

		// bus sequencing: one wait state, answer in the second access cycle
		unique case (s_r.bus)
			PWIE_IDLE: begin
				if (psel_in && penable_in) begin
					s_nxt.bus = PWIE_ACK;
				end
			end
			PWIE_ACK: begin
				s_nxt.bus = PWIE_IDLE;
			end
		endcase

		for (int p = 0; p < PWIE_PORTS; p++) begin
			// software clear by writing one; the event set below comes last so it wins
			if (wr_en && port_sel[p] && hit_wflags) begin
				s_nxt.port[p].wake_flags = s_r.port[p].wake_flags & ~wd[2:0];
			end
			// enables are plain storage; link and energy enables do not exist off a phy port
			if (wr_en && port_sel[p] && hit_wen) begin
				s_nxt.port[p].wake_en = wd[2:0] & {1'b1, PHY_PORTS[p], PHY_PORTS[p]};
			end
			if (wr_en && port_sel[p] && hit_imask) begin
				// a changed filter mask bit is the only way software clears the filter status
				if (wd[`PWIE_BIT_FILTER_INT] != s_r.port[p].mask[`PWIE_BIT_FILTER_INT]) begin
					s_nxt.port[p].filter_flag = 1'b0;
				end
				s_nxt.port[p].mask[`PWIE_BIT_PHY_INT] = wd[`PWIE_BIT_PHY_INT] & PHY_PORTS[p];
				s_nxt.port[p].mask[`PWIE_BIT_FILTER_INT] = wd[`PWIE_BIT_FILTER_INT];
			end
			s_nxt.port[p].wake_flags = s_nxt.port[p].wake_flags | wake_set[p];
			// filter event is same-domain; set beats the mask-toggle clear
			if (filter_int_in[p]) begin
				s_nxt.port[p].filter_flag = 1'b1;
			end
			// any port may request the pin
			pev = pev | wake_hit[p];
			// only the addressed page contributes read data
			if (port_sel[p]) begin
				rd = rd | port_rd[p];
			end
		end

		// block interrupt: a pending port keeps its sticky bit set, write one to clear;
		// a still pending port sets its bit again in the same cycle, so no event is lost
		if (wr_en && hit_gstat) begin
			s_nxt.irq_status = s_r.irq_status & ~pwdata_in[PWIE_PORTS-1:0];
		end
		if (wr_en && hit_gmask) begin
			s_nxt.irq_mask = pwdata_in[PWIE_PORTS-1:0];
		end
		s_nxt.irq_status = s_nxt.irq_status | pend;
		if (hit_gstat) begin
			rd[PWIE_PORTS-1:0] = s_r.irq_status;
		end
		if (hit_gmask) begin
			rd[PWIE_PORTS-1:0] = s_r.irq_mask;
		end

		// read data is captured in the first access cycle and shown with ready
		if (rd_en) begin
			s_nxt.prdata = {24'h0, rd};
		end
		// unmapped address answers with an error and reads zero
		if (access) begin
			s_nxt.pslverr = !(hit_port || hit_glob);
		end
		// pins follow registered state, one edge behind the flags
		s_nxt.power_event = pev;
		s_nxt.irq = |(s_r.irq_status & s_r.irq_mask);
	end

	// single state register; reset values are constants only
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s_r <= '0;
			s_r.bus <= PWIE_IDLE;
			for (int p = 0; p < PWIE_PORTS; p++) begin
				s_r.port[p].wake_flags <= `PWIE_RST_WAKE;
				s_r.port[p].wake_en <= `PWIE_RST_WAKE;
				s_r.port[p].mask <= `PWIE_RST_MASK;
			end
			s_r.irq_mask <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from flip-flops; the bus state is one-hot so ready is a flop bit
	assign pready_out = (s_r.bus == PWIE_ACK);
	assign prdata_out = s_r.prdata;
	assign pslverr_out = s_r.pslverr;
	assign power_event_out = s_r.power_event;
	assign irq_out = s_r.irq;

	// limitations: the filter event must be a pulse on this clock, a held level
	// keeps its status set; the phy summary is not sticky and follows the phy level.
	// the global interrupt registers live in page 0 next to nothing else of this block.

endmodule : pwie_top

/* src/pwie_map.svh */
// register map, field positions and reset values of the port wake and interrupt event block
// assumes a 32-bit apb slave with one aligned word per register
`ifndef PWIE_MAP_SVH
`define PWIE_MAP_SVH
// printed offsets are not multiples of four, so they are register indices within a port page
`define PWIE_IDX_WAKE_FLAGS 12'h013
`define PWIE_IDX_WAKE_ENABLES 12'h017
`define PWIE_IDX_INT_FLAGS 12'h01B
`define PWIE_IDX_INT_MASK 12'h01F
// global block interrupt registers, index within page 0
`define PWIE_IDX_IRQ_STATUS 12'h001
`define PWIE_IDX_IRQ_MASK 12'h002
// port page field of the byte address, port n in 1..6
`define PWIE_PAGE_MSB 15
`define PWIE_PAGE_LSB 12
// bit positions
`define PWIE_BIT_WAKE_PKT 2
`define PWIE_BIT_LINK_UP 1
`define PWIE_BIT_ENERGY 0
`define PWIE_BIT_PHY_INT 1
`define PWIE_BIT_FILTER_INT 0
// reset values
`define PWIE_RST_WAKE 3'h0
`define PWIE_RST_MASK 2'h0
`define PWIE_RST_IRQ_MASK 8'h00
`endif

/* src/pwie_pkg.sv */
// types for the port wake and interrupt event block
// used by the top module and the bench monitor
package pwie_pkg;
	parameter int PWIE_PORTS = 6;

	// per-port raw event inputs after synchronisation
	typedef struct packed {
		logic wake_pkt;
		logic link_up;
		logic energy;
		logic phy_int;
		logic filter_int;
	} pwie_evt_t;

	// per-port register state
	typedef struct packed {
		logic [2:0] wake_flags;
		logic [2:0] wake_en;
		logic filter_flag;
		logic [1:0] mask;
	} pwie_port_t;

	typedef enum logic [1:0] {
		PWIE_IDLE = 2'b01,
		PWIE_ACK = 2'b10
	} pwie_bus_state_t;

	// state of the block apart from the synchronisers
	typedef struct packed {
		pwie_port_t [PWIE_PORTS-1:0] port;
		logic [PWIE_PORTS-1:0] irq_status;
		logic [PWIE_PORTS-1:0] irq_mask;
		pwie_bus_state_t bus;
		logic [31:0] prdata;
		logic pslverr;
		logic power_event;
		logic irq;
	} pwie_state_t;
endpackage : pwie_pkg

/* tb/pwie_monitor.sv */
// port-side checker for the wake and interrupt event block
// bound onto pwie_top from the bench top file
`timescale 1ns/1ps
module pwie_monitor
	import pwie_pkg::*;
#(parameter int PORTS = PWIE_PORTS) (
	// clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// apb
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [15:0] paddr_in,
	input wire logic pready_out,
	input wire logic [31:0] prdata_out,
	input wire logic pslverr_out,
	// pins
	input wire logic power_event_out,
	input wire logic irq_out
);
	logic [2:0] wr_hist_r;
	// accepted writes of the last three edges, the only legal cause of a falling pin
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wr_hist_r <= 3'h0;
		end else begin
			wr_hist_r <= {wr_hist_r[1:0], pready_out && pwrite_in};
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	// setup cycle of a transfer
	sequence s_setup;
		psel_in && !penable_in;
	endsequence
	a_one_wait_state: assert property (s_setup |-> ##2 pready_out)
		else $error("ready not after one wait state");
	a_ready_one_cycle: assert property (pready_out |=> !pready_out)
		else $error("ready held");
	a_ready_in_access: assert property (
		pready_out |-> psel_in && penable_in && $past(penable_in))
		else $error("ready outside access");
	a_err_reads_zero: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
		else $error("error with data");
	a_upper_bits_zero: assert property (pready_out |-> prdata_out[31:8] == 24'h0)
		else $error("reserved bits set");
	a_err_unmapped: assert property (pslverr_out |-> !(paddr_in[15:12] inside {[1:6]} &&
		paddr_in[11:2] inside {10'h013, 10'h017, 10'h01B, 10'h01F}))
		else $error("error on mapped register");
	a_pin_falls_write: assert property ($fell(power_event_out) |-> |wr_hist_r[1:0])
		else $error("pin fell without write");
	a_irq_falls_write: assert property ($fell(irq_out) |-> |wr_hist_r)
		else $error("irq fell without write");
endmodule : pwie_monitor

/* tb/pwie_pm_model.sv */
// power manager model: counts wake requests seen on the power event pin
// assumes the pin is a level in the block's clock domain
`timescale 1ns/1ps
module pwie_pm_model (
	// clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// pin and request count
	input wire logic power_event_in,
	output logic [7:0] wakes_out
);
	logic seen_r;
	// a held pin is one request, so only rising levels count
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			seen_r <= 1'b0;
			wakes_out <= 8'h00;
		end else begin
			seen_r <= power_event_in;
			wakes_out <= wakes_out + {7'h00, power_event_in && !seen_r};
		end
	end
endmodule : pwie_pm_model

/* tb/tb_top.sv */
// bench for the wake and interrupt block: apb master, event drivers, power manager
// assumes the map header and a single 50 MHz clock
`timescale 1ns/1ps
`include "pwie_map.svh"
module tb_top;
	logic clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic psel_in = 1'b0;
	logic penable_in = 1'b0;
	logic pwrite_in = 1'b0;
	logic [15:0] paddr_in = 16'h0000;
	logic [31:0] pwdata_in = 32'h0;
	logic [3:0] pstrb_in = 4'hF;
	logic [5:0] wake_pkt_in = 6'h00, link_up_in = 6'h00, energy_in = 6'h00;
	logic [5:0] phy_int_in = 6'h00, filter_int_in = 6'h00;
	logic pready_out, pslverr_out, power_event_out, irq_out, er;
	logic [31:0] prdata_out, rd;
	logic [7:0] wakes;
	int err_total = 0, samples_checked = 0, exp_wakes = 0;
	always #10 clk_in = ~clk_in;
	pwie_top uut (.clk_in, .arst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
		.pwdata_in, .pstrb_in, .pready_out, .prdata_out, .pslverr_out, .wake_pkt_in,
		.link_up_in, .energy_in, .phy_int_in, .filter_int_in, .power_event_out, .irq_out);
	pwie_pm_model u_pm (.clk_in, .arst_n_in, .power_event_in(power_event_out), .wakes_out(wakes));
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task automatic report_and_stop();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop
	// one apb transfer; the request is held until ready is sampled high
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 20);
		rd = prdata_out;
		er = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		if (pready_out !== 1'b1) begin
			err_total++;
			report_and_stop();
		end
	endtask : apb
	// byte address of a register index in a port page
	function automatic logic [15:0] ra(input int p, input logic [11:0] i);
		return {p[3:0], i[9:0], 2'b00};
	endfunction : ra
	initial begin
		int p;
		logic [2:0] ev, en, pm;
		void'($urandom(32'hC77DBE70));
		repeat (10) @(posedge clk_in);
		arst_n_in <= 1'b1;
		// all four registers of every port page come up clear
		for (p = 1; p <= 6; p++) begin
			for (int k = 0; k < 4; k++) begin
				apb(1'b0, ra(p, `PWIE_IDX_WAKE_FLAGS + 12'(k * 4)), 32'h0);
				chk("reset value", rd, 32'h0);
			end
		end
		// wake events, first every source enabled, then random mixes
		for (int i = 0; i < 18; i++) begin
			p = i % 6;
			pm = (p < 5) ? 3'h7 : 3'h4;
			ev = (i < 6) ? 3'h7 : 3'($urandom);
			en = (i < 6) ? 3'h7 : 3'($urandom);
			apb(1'b1, ra(p + 1, `PWIE_IDX_WAKE_ENABLES), {29'($urandom), en});
			apb(1'b0, ra(p + 1, `PWIE_IDX_WAKE_ENABLES), 32'h0);
			chk("enables", rd, {29'h0, en & pm});
			wake_pkt_in[p] <= ev[2];
			link_up_in[p] <= ev[1];
			energy_in[p] <= ev[0];
			repeat (8) @(posedge clk_in);
			chk("pin", power_event_out, {31'h0, |(ev & en & pm)});
			exp_wakes += |(ev & en & pm);
			wake_pkt_in[p] <= 1'b0;
			link_up_in[p] <= 1'b0;
			energy_in[p] <= 1'b0;
			repeat (8) @(posedge clk_in);
			apb(1'b0, ra(p + 1, `PWIE_IDX_WAKE_FLAGS), 32'h0);
			chk("flags", rd, {29'h0, ev & pm});
			apb(1'b1, ra(p + 1, `PWIE_IDX_WAKE_FLAGS), 32'h7);
			apb(1'b0, ra(p + 1, `PWIE_IDX_WAKE_FLAGS), 32'h0);
			chk("flags cleared", rd, 32'h0);
			chk("pin idle", power_event_out, 32'h0);
		end
		chk("wake count", {24'h0, wakes}, exp_wakes);
		// port interrupts through the global mask, every port in turn
		apb(1'b1, 16'h0008, 32'h3F);
		for (p = 0; p < 6; p++) begin
			pm = (p < 5) ? 3'h2 : 3'h0;
			phy_int_in[p] <= 1'b1;
			filter_int_in[p] <= 1'b1;
			@(posedge clk_in);
			filter_int_in[p] <= 1'b0;
			repeat (6) @(posedge clk_in);
			chk("irq", irq_out, 32'h1);
			apb(1'b1, ra(p + 1, `PWIE_IDX_INT_FLAGS), 32'hFF);
			apb(1'b0, ra(p + 1, `PWIE_IDX_INT_FLAGS), 32'h0);
			chk("status", rd, {30'h0, pm[1], 1'b1});
			apb(1'b1, ra(p + 1, `PWIE_IDX_INT_MASK), 32'h3);
			apb(1'b0, ra(p + 1, `PWIE_IDX_INT_MASK), 32'h0);
			chk("mask", {31'h0, rd[0]}, 32'h1);
			apb(1'b0, ra(p + 1, `PWIE_IDX_INT_FLAGS), 32'h0);
			chk("status toggled", rd, {30'h0, pm[1], 1'b0});
			apb(1'b1, 16'h0004, 32'h3F);
			repeat (4) @(posedge clk_in);
			chk("masked irq", irq_out, 32'h0);
			apb(1'b1, ra(p + 1, `PWIE_IDX_INT_MASK), 32'h0);
			repeat (6) @(posedge clk_in);
			chk("unmasked irq", irq_out, {31'h0, pm[1]});
			phy_int_in[p] <= 1'b0;
			apb(1'b1, 16'h0004, 32'h3F);
		end
		// global mask reads back; a write without byte lane 0 is ignored
		apb(1'b0, 16'h0008, 32'h0);
		chk("irq mask", rd, 32'h3F);
		apb(1'b1, ra(1, `PWIE_IDX_WAKE_ENABLES), 32'h5);
		pstrb_in <= 4'hE;
		apb(1'b1, ra(1, `PWIE_IDX_WAKE_ENABLES), 32'h0);
		pstrb_in <= 4'hF;
		apb(1'b0, ra(1, `PWIE_IDX_WAKE_ENABLES), 32'h0);
		chk("strobe ignored", rd, 32'h5);
		// an unmapped word is refused and reads zero
		apb(1'b0, 16'h0FFC, 32'h0);
		chk("unmapped err", {31'h0, er}, 32'h1);
		chk("unmapped data", rd, 32'h0);
		report_and_stop();
	end
endmodule : tb_top
bind pwie_top pwie_monitor #(.PORTS(PORTS)) u_mon (.*);
